// ### inc/reset_cause_pkg.sv
// constants of the reset cause flag block: register map, bit positions,
// values after reset and bus answer codes.
// assumes a 32-bit AXI4-Lite register bus with word-aligned offsets.
package reset_cause_pkg;

	// register byte offsets
	localparam logic [7:0] CAUSE_OFFSET      = 8'h00;
	localparam logic [7:0] EVENT_STAT_OFFSET = 8'h04;
	localparam logic [7:0] EVENT_CLR_OFFSET  = 8'h08;
	localparam logic [7:0] EVENT_EN_OFFSET   = 8'h0C;
	localparam logic [7:0] CONFIG_OFFSET     = 8'h10;

	// bit positions in the reset cause register
	localparam int OVF_BIT   = 7;
	localparam int UNF_BIT   = 6;
	localparam int PIN_BIT   = 3;
	localparam int INSTR_BIT = 2;
	localparam int PWR_BIT   = 1;
	localparam int BROWN_BIT = 0;

	localparam int CAUSE_W = 8;
	localparam int EVENT_W = 6;

	// implemented bits; bits 5 and 4 stay zero
	localparam logic [7:0] CAUSE_IMPL  = 8'hCF;
	// value after reset, as after a power-on reset
	localparam logic [7:0] CAUSE_RESET = 8'h0C;
	localparam logic [5:0] EVENT_RESET = 6'h00;
	localparam logic [5:0] EN_RESET    = 6'h00;
	localparam logic       CFG_RESET   = 1'b0;

	// event status bit positions
	localparam int EV_OVF   = 5;
	localparam int EV_UNF   = 4;
	localparam int EV_PIN   = 3;
	localparam int EV_INSTR = 2;
	localparam int EV_PWR   = 1;
	localparam int EV_BROWN = 0;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : reset_cause_pkg

// ### src/reset_cause_flags.sv
// reset cause flag register with an AXI4-Lite slave and event interrupt.
// assumes event strobes are one-cycle, synchronous to aclk, and that the
// surrounding reset logic acts on device_reset_request.
//
// Functional notes
// - A stack overflow sets bit 7, which holds until firmware writes zero.
// - A stack underflow sets bit 6, which holds until firmware writes zero.
// - A reset through the external pin clears bit 3; firmware may set it.
// - A reset instruction clears bit 2; firmware may write one to restore it.
// - A power-on reset clears bit 1 and software then writes it to one.
// - A brown-out reset clears bit 0 and software then writes it to one.
// - Power-on or brown-out puts bits 7 and 6 to zero, bits 3 and 2 to one.
// - Stack faults request a device reset only while the enable bit is set.
`timescale 1ns/1ns

module reset_cause_flags (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address channel
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// write data channel
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// write response channel
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// read address channel
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// read data channel
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// reset cause strobes
	input  wire logic        power_on_event,
	input  wire logic        brownout_event,
	input  wire logic        pin_reset_event,
	input  wire logic        reset_instr_event,
	input  wire logic        stack_overflow_event,
	input  wire logic        stack_underflow_event,
	// outputs to the system
	output logic             device_reset_request,
	output logic             irq
);

	// stored state
	logic [7:0]  reset_cause_register;
	logic [5:0]  event_status;
	logic [5:0]  event_enable;
	logic        stack_fault_reset_enable;
	logic        aw_full;
	logic        w_full;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// write path decode
	logic        aw_take;
	logic        w_take;
	logic        do_write;
	logic        next_aw_full;
	logic        next_w_full;
	logic        lane0;
	logic        wr_cause;
	logic        wr_clr;
	logic        wr_en;
	logic        wr_cfg;
	logic        wr_hit;

	assign aw_take      = awvalid & awready;
	assign w_take       = wvalid & wready;
	assign do_write     = aw_full & w_full & ~bvalid;
	assign next_aw_full = (aw_full & ~do_write) | aw_take;
	assign next_w_full  = (w_full & ~do_write) | w_take;
	assign lane0        = do_write & w_strb[0];
	assign wr_cause     = lane0 && aw_addr == reset_cause_pkg::CAUSE_OFFSET;
	assign wr_clr       = lane0 && aw_addr == reset_cause_pkg::EVENT_CLR_OFFSET;
	assign wr_en        = lane0 && aw_addr == reset_cause_pkg::EVENT_EN_OFFSET;
	assign wr_cfg       = lane0 && aw_addr == reset_cause_pkg::CONFIG_OFFSET;
	assign wr_hit       = aw_addr == reset_cause_pkg::CAUSE_OFFSET
		|| aw_addr == reset_cause_pkg::EVENT_STAT_OFFSET
		|| aw_addr == reset_cause_pkg::EVENT_CLR_OFFSET
		|| aw_addr == reset_cause_pkg::EVENT_EN_OFFSET
		|| aw_addr == reset_cause_pkg::CONFIG_OFFSET;

	// hardware set and clear per cause bit
	logic        pwr_init;
	logic [7:0]  hw_set;
	logic [7:0]  hw_clr;
	logic [7:0]  next_cause;

	assign pwr_init = power_on_event | brownout_event;

	always_comb begin
		hw_set = 8'h00;
		hw_clr = 8'h00;
		// power-on and brown-out outrank every other cause
		hw_set[reset_cause_pkg::OVF_BIT]   = stack_overflow_event & ~pwr_init;
		hw_clr[reset_cause_pkg::OVF_BIT]   = pwr_init;
		hw_set[reset_cause_pkg::UNF_BIT]   = stack_underflow_event & ~pwr_init;
		hw_clr[reset_cause_pkg::UNF_BIT]   = pwr_init;
		hw_set[reset_cause_pkg::PIN_BIT]   = pwr_init;
		hw_clr[reset_cause_pkg::PIN_BIT]   = pin_reset_event & ~pwr_init;
		hw_set[reset_cause_pkg::INSTR_BIT] = pwr_init;
		hw_clr[reset_cause_pkg::INSTR_BIT] = reset_instr_event & ~pwr_init;
		hw_clr[reset_cause_pkg::PWR_BIT]   = power_on_event;
		// the brown-out bit is undefined after power-on; it is cleared
		hw_clr[reset_cause_pkg::BROWN_BIT] = pwr_init;
	end

	// per bit: hardware event first, then firmware write, else hold
	genvar gi;
	generate
		for (gi = 0; gi < reset_cause_pkg::CAUSE_W; gi++) begin : g_bit
			assign next_cause[gi] = !reset_cause_pkg::CAUSE_IMPL[gi] ? 1'b0
				: hw_set[gi] ? 1'b1
				: hw_clr[gi] ? 1'b0
				: wr_cause ? w_data[gi]
				: reset_cause_register[gi];
		end
	endgenerate

	// event status: set wins over a clear in the same cycle
	logic [5:0]  ev_in;
	logic [5:0]  next_status;
	logic [5:0]  next_enable;

	assign ev_in = {stack_overflow_event, stack_underflow_event,
		pin_reset_event, reset_instr_event, power_on_event, brownout_event};
	assign next_status = (event_status & ~(wr_clr ? w_data[5:0] : 6'h00))
		| ev_in;
	assign next_enable = wr_en ? w_data[5:0] : event_enable;

	logic        stack_fault;
	assign stack_fault = (stack_overflow_event | stack_underflow_event)
		& stack_fault_reset_enable;

	// read decode
	logic        ar_take;
	logic        rd_hit;
	logic [31:0] rd_word;

	assign ar_take = arvalid & arready;
	assign rd_hit  = araddr == reset_cause_pkg::CAUSE_OFFSET
		|| araddr == reset_cause_pkg::EVENT_STAT_OFFSET
		|| araddr == reset_cause_pkg::EVENT_CLR_OFFSET
		|| araddr == reset_cause_pkg::EVENT_EN_OFFSET
		|| araddr == reset_cause_pkg::CONFIG_OFFSET;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (araddr)
			reset_cause_pkg::CAUSE_OFFSET:
				rd_word = {24'h000000, reset_cause_register};
			reset_cause_pkg::EVENT_STAT_OFFSET:
				rd_word = {26'h0, event_status};
			reset_cause_pkg::EVENT_EN_OFFSET:
				rd_word = {26'h0, event_enable};
			reset_cause_pkg::CONFIG_OFFSET:
				rd_word = {31'h0, stack_fault_reset_enable};
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	// flag state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_cause_register     <= reset_cause_pkg::CAUSE_RESET;
			event_status             <= reset_cause_pkg::EVENT_RESET;
			event_enable             <= reset_cause_pkg::EN_RESET;
			stack_fault_reset_enable <= reset_cause_pkg::CFG_RESET;
			device_reset_request     <= 1'b0;
			irq                      <= 1'b0;
		end else begin
			reset_cause_register <= next_cause;
			event_status         <= next_status;
			event_enable         <= next_enable;
			if (wr_cfg) begin
				stack_fault_reset_enable <= w_data[0];
			end
			device_reset_request <= stack_fault;
			irq                  <= |(next_status & next_enable);
		end
	end

	// write channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			aw_full <= next_aw_full;
			w_full  <= next_w_full;
			awready <= ~next_aw_full;
			wready  <= ~next_w_full;
			if (aw_take) begin
				aw_addr <= awaddr;
			end
			if (w_take) begin
				w_data <= wdata;
				w_strb <= wstrb;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= reset_cause_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? reset_cause_pkg::RESP_OKAY
				: reset_cause_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= reset_cause_pkg::RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= rd_hit ? reset_cause_pkg::RESP_OKAY
				: reset_cause_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// checks
	ovf_sets_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		stack_overflow_event && !pwr_init |=> reset_cause_register[7]
		##1 (reset_cause_register[7] || $past(wr_cause) || $past(pwr_init)))
		else $error("stack overflow flag not set");

	unf_sets_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		stack_underflow_event && !pwr_init |=> reset_cause_register[6])
		else $error("stack underflow flag not set");

	unimpl_zero_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		rvalid && $past(ar_take) && $past(araddr) == 8'h00
		|-> rdata[5:4] == 2'h0 && reset_cause_register[5:4] == 2'h0)
		else $error("unimplemented cause bits not zero");

	pin_clears_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		pin_reset_event && !pwr_init |=> !reset_cause_register[3])
		else $error("pin reset flag not cleared");

	instr_clears_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		reset_instr_event && !pwr_init |=> !reset_cause_register[2])
		else $error("reset instruction flag not cleared");

	pwr_clears_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		power_on_event |=> !reset_cause_register[1]
		&& !reset_cause_register[0])
		else $error("power-on flag not cleared");

	brown_clears_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		brownout_event && !power_on_event && !wr_cause
		|=> !reset_cause_register[0]
		&& reset_cause_register[1] == $past(reset_cause_register[1]))
		else $error("brown-out flag wrong");

	pwr_init_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		pwr_init |=> reset_cause_register[7:6] == 2'h0
		&& reset_cause_register[3:2] == 2'h3)
		else $error("power init values wrong");

	fault_reset_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		##1 device_reset_request == ($past(stack_fault_reset_enable)
		&& ($past(stack_overflow_event) || $past(stack_underflow_event))))
		else $error("stack fault reset request wrong");

	hw_priority_a: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wr_cause && !w_data[6] && stack_underflow_event && !pwr_init
		|=> reset_cause_register[6])
		else $error("firmware write beat hardware event");

endmodule : reset_cause_flags

// ### tb/reset_cause_flags_test.sv
// self-checking bench for the reset cause flag block.
// assumes the package is compiled first and the block answers on AXI4-Lite.
`timescale 1ns/1ns

module reset_cause_flags_test;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [5:0]  ev, ev_wr;
	logic        device_reset_request, irq, dq, iq;
	int          err_count, n_checks;
	localparam logic [7:0] CA = reset_cause_pkg::CAUSE_OFFSET;
	localparam logic [7:0] ST = reset_cause_pkg::EVENT_STAT_OFFSET;
	localparam logic [7:0] CL = reset_cause_pkg::EVENT_CLR_OFFSET;
	localparam logic [7:0] EN = reset_cause_pkg::EVENT_EN_OFFSET;
	localparam logic [7:0] CF = reset_cause_pkg::CONFIG_OFFSET;
	localparam logic [1:0] OK = reset_cause_pkg::RESP_OKAY;
	localparam logic [1:0] ER = reset_cause_pkg::RESP_SLVERR;

	// ev bits: 5 overflow, 4 underflow, 3 pin, 2 instr, 1 power-on, 0 brown-out
	reset_cause_flags dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.power_on_event(ev[1]), .brownout_event(ev[0]),
		.pin_reset_event(ev[3]), .reset_instr_event(ev[2]),
		.stack_overflow_event(ev[5]), .stack_underflow_event(ev[4]),
		.device_reset_request(device_reset_request), .irq(irq)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// ev_wr is strobed so that it lands in the cycle the write executes
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic awd, wd, go;
		int   n;
		awd = 1'b0;
		wd = 1'b0;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			go = !(awd && wd);
			if (awvalid && awready) awd = 1'b1;
			if (wvalid && wready) wd = 1'b1;
			awvalid <= !awd;
			wvalid <= !wd;
			ev <= (go && awd && wd) ? ev_wr : 6'h00;
			n++;
		end while (!(bvalid && bready) && n < 100);
		if (!(bvalid && bready)) err_count++;
		bready <= 1'b0;
		chk(bresp, er);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			n++;
		end while (!(rvalid && rready) && n < 100);
		if (!(rvalid && rready)) err_count++;
		rready <= 1'b0;
		chk(rdata, ed);
		chk(rresp, er);
	endtask : rc

	task automatic pulse(input logic [5:0] v);
		@(posedge aclk);
		ev <= v;
		@(posedge aclk);
		ev <= 6'h00;
		#1;
		dq = device_reset_request;
		iq = irq;
	endtask : pulse

	task automatic t_reset;
		rc(CA, 32'h0000_000C, OK);
		rc(ST, 32'h0, OK);
		rc(8'h14, 32'h0, ER);
		wr(8'h14, 32'h0000_00FF, ER);
		$display("test reset done");
	endtask : t_reset

	task automatic t_stack;
		wr(CF, 32'h0, OK);
		pulse(6'h20);
		chk(dq, 1'b0);
		rc(CA, 32'h0000_008C, OK);
		pulse(6'h10);
		rc(CA, 32'h0000_00CC, OK);
		wr(CA, 32'h0000_004C, OK);
		rc(CA, 32'h0000_004C, OK);
		wr(CA, 32'h0000_000C, OK);
		rc(CA, 32'h0000_000C, OK);
		wr(CF, 32'h1, OK);
		pulse(6'h10);
		chk(dq, 1'b1);
		rc(CA, 32'h0000_004C, OK);
		pulse(6'h08);
		chk(dq, 1'b0);
		$display("test stack done");
	endtask : t_stack

	task automatic t_flags;
		wr(CA, 32'h0000_00FF, OK);
		rc(CA, 32'h0000_00CF, OK);
		wr(CA, 32'h0000_0030, OK);
		rc(CA, 32'h0, OK);
		wr(CA, 32'h0000_000F, OK);
		pulse(6'h08);
		rc(CA, 32'h0000_0007, OK);
		wr(CA, 32'h0000_000F, OK);
		rc(CA, 32'h0000_000F, OK);
		pulse(6'h04);
		rc(CA, 32'h0000_000B, OK);
		wr(CA, 32'h0000_000F, OK);
		rc(CA, 32'h0000_000F, OK);
		$display("test flags done");
	endtask : t_flags

	task automatic t_power;
		wr(CA, 32'h0000_00FF, OK);
		pulse(6'h02);
		rc(CA, 32'h0000_000C, OK);
		wr(CA, 32'h0000_000F, OK);
		rc(CA, 32'h0000_000F, OK);
		wr(CA, 32'h0000_00C3, OK);
		pulse(6'h01);
		rc(CA, 32'h0000_000E, OK);
		wr(CA, 32'h0000_000F, OK);
		rc(CA, 32'h0000_000F, OK);
		$display("test power done");
	endtask : t_power

	task automatic t_race;
		ev_wr = 6'h38;
		wr(CA, 32'h0000_000F, OK);
		ev_wr = 6'h00;
		rc(CA, 32'h0000_00C7, OK);
		// status set and clear of one bit in one cycle: the set wins
		ev_wr = 6'h10;
		wr(CL, 32'h0000_0010, OK);
		ev_wr = 6'h00;
		rc(ST, 32'h0000_003F, OK);
		$display("test race done");
	endtask : t_race

	task automatic t_irq;
		wr(CL, 32'h0000_003F, OK);
		rc(ST, 32'h0, OK);
		wr(EN, 32'h0000_0020, OK);
		pulse(6'h10);
		chk(iq, 1'b0);
		pulse(6'h20);
		chk(iq, 1'b1);
		rc(ST, 32'h0000_0030, OK);
		wr(ST, 32'h0, OK);
		rc(ST, 32'h0000_0030, OK);
		wr(CL, 32'h0000_0010, OK);
		rc(ST, 32'h0000_0020, OK);
		chk(irq, 1'b1);
		wr(CL, 32'h0000_0020, OK);
		rc(EN, 32'h0000_0020, OK);
		chk(irq, 1'b0);
		rc(CL, 32'h0, OK);
		$display("test irq done");
	endtask : t_irq

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// whole run takes well under a thousand cycles
	initial begin
		#100000;
		err_count++;
		summarize;
	end

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		ev = 6'h00;
		ev_wr = 6'h00;
		err_count = 0;
		n_checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_stack;
		t_flags;
		t_power;
		t_race;
		t_irq;
		summarize;
	end
endmodule : reset_cause_flags_test
